// *** tb_vtie_vlan_tag.sv ***
// testbench for the vlan tag ingress/egress block
`timescale 1ns/1ns
`default_nettype none
module tb_vtie_vlan_tag
    import vtie_pkg::*;
;
    logic clk_sys_i, reset_i, reg_wr_i, reg_rd_i, cl_valid_i, cl_tagged_i, cl_to_mgmt_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [PORT_W-1:0] cl_port_i;
    logic [11:0] cl_vid_i, cl_vid_o, eg_vid_i;
    logic [NPORT-1:0] cl_dest_i, cl_fwd_o, cl_tag_o;
    logic cl_done_o, cl_drop_o, cl_mgmt_o, eg_valid_i, eg_last_i, eg_ready_o, out_valid_o, out_last_o;
    logic [7:0] eg_data_i, out_data_o;
    vtie_eg_mode_t eg_mode_i;
    int mismatches, n_checks;
    logic [7:0] base[$], tagd[$];

    vtie_vlan_tag i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cl_valid_i(cl_valid_i), .cl_port_i(cl_port_i), .cl_tagged_i(cl_tagged_i), .cl_vid_i(cl_vid_i),
        .cl_dest_i(cl_dest_i), .cl_to_mgmt_i(cl_to_mgmt_i), .cl_done_o(cl_done_o), .cl_drop_o(cl_drop_o),
        .cl_vid_o(cl_vid_o), .cl_fwd_o(cl_fwd_o), .cl_tag_o(cl_tag_o), .cl_mgmt_o(cl_mgmt_o),
        .eg_valid_i(eg_valid_i), .eg_data_i(eg_data_i), .eg_last_i(eg_last_i), .eg_mode_i(eg_mode_i),
        .eg_vid_i(eg_vid_i), .eg_ready_o(eg_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .out_last_o(out_last_o));
    vtie_far_end far (.clk_sys_i(clk_sys_i), .eg_ready_i(eg_ready_o), .eg_valid_o(eg_valid_i),
        .eg_data_o(eg_data_i), .eg_last_o(eg_last_i), .eg_mode_o(eg_mode_i), .eg_vid_o(eg_vid_i),
        .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_last_i(out_last_o));
    // ============================================================
    // helpers
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a; reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk("read data", reg_rdata_o, exp);
    endtask : rd
    function automatic logic [31:0] res(logic dr, logic [4:0] f, logic [4:0] t, logic m, logic [11:0] v);
        return {7'h00, 1'b1, dr, f, t, m, v};
    endfunction : res
    task cls(input logic [2:0] p, input logic tg, input logic [11:0] v, input logic [4:0] d,
             input logic m, input logic [31:0] ex);
        logic [31:0] seen;
        @(posedge clk_sys_i);
        cl_valid_i <= 1'b1; cl_port_i <= p; cl_tagged_i <= tg; cl_vid_i <= v; cl_dest_i <= d; cl_to_mgmt_i <= m;
        @(posedge clk_sys_i);
        cl_valid_i <= 1'b0;
        #1 seen = {7'h00, cl_done_o, cl_drop_o, cl_fwd_o, cl_tag_o, cl_mgmt_o, cl_vid_o};
        if (ex[23]) seen[11:0] = 12'h000;
        chk("classify", seen, ex);
    endtask : cls
    function automatic logic [31:0] crc(input logic [7:0] q[$]);
        logic [31:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {24'h0, q[i]};
            repeat (8) c = (c >> 1) ^ (c[0] ? CRC_POLY : 32'h0);
        end
        return ~c;
    endfunction : crc
    task egress(input logic [7:0] frm[$], input vtie_eg_mode_t md, input logic [7:0] ex[$]);
        logic [31:0] c;
        far.rx.delete();
        far.last_at = 0;
        @(posedge clk_sys_i);
        far.send(frm, md, 12'h005);
        for (int k = 0; k < 20 && far.last_at == 0; k++) @(posedge clk_sys_i);
        c = crc(ex);
        ex = {ex, c[7:0], c[15:8], c[23:16], c[31:24]};
        chk("egress length", far.rx.size(), ex.size());
        chk("egress last", far.last_at, ex.size());
        foreach (ex[i]) chk("egress byte", {24'h0, far.rx[i]}, {24'h0, ex[i]});
    endtask : egress
    // ============================================================
    // clock, watchdog, tests
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        mismatches++;
        give_verdict();
    end
    initial begin
        {reset_i, reg_wr_i, reg_rd_i, cl_valid_i, cl_tagged_i, cl_to_mgmt_i} = 6'b100000;
        {reg_addr_i, reg_wdata_i, cl_port_i, cl_vid_i, cl_dest_i} = '0;
        mismatches = 0; n_checks = 0;
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(8'h00, 32'h0000_0001);
        rd(8'h40, 32'h0000_8001);
        rd(8'h44, 32'h0000_0000);
        rd(8'hfc, 32'h0000_0000);
        cls(0, 0, 12'h000, 5'b00110, 1, res(0, 5'b00110, 5'b00000, 1, 12'h001));
        cls(0, 1, 12'h005, 5'b00110, 0, res(1, 5'b00000, 5'b00000, 0, 12'h000));
        wr(8'h44, 32'h0004_8005);
        wr(8'h00, 32'h0000_0005);
        wr(8'h08, 32'h0001_0001);
        wr(8'h04, 32'h0000_0000);
        wr(8'h04, 32'h0000_0fff);
        rd(8'h04, 32'h0000_0001);
        cls(0, 0, 12'h000, 5'b00110, 1, res(0, 5'b00100, 5'b00100, 0, 12'h005));
        cls(2, 1, 12'h005, 5'b00011, 0, res(0, 5'b00001, 5'b00000, 0, 12'h005));
        cls(2, 0, 12'h000, 5'b00010, 0, res(0, 5'b00010, 5'b00000, 0, 12'h001));
        cls(1, 1, 12'h005, 5'b00001, 0, res(1, 5'b00000, 5'b00000, 0, 12'h000));
        wr(8'h08, 32'h0000_0001);
        cls(2, 1, 12'h005, 5'b00001, 0, res(1, 5'b00000, 5'b00000, 0, 12'h000));
        cls(5, 0, 12'h000, 5'b00001, 0, res(1, 5'b00000, 5'b00000, 0, 12'h000));
        rd(8'h80, 32'h0004_0004);
        for (int i = 0; i < 14; i++) base.push_back(8'(i * 7 + 1));
        tagd = {base[0:11], 8'h81, 8'h00, 8'h00, 8'h05, base[12:13]};
        egress(base, EG_INSERT, tagd);
        egress(tagd, EG_STRIP, base);
        egress(tagd, EG_KEEP, tagd);
        give_verdict();
    end
endmodule : tb_vtie_vlan_tag
`default_nettype wire

// *** vtie_far_end.sv ***
// far side model: frame source into the egress editor and sink of its output
`timescale 1ns/1ns
`default_nettype none
module vtie_far_end
    import vtie_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       eg_ready_i,
    output logic            eg_valid_o,
    output logic [7:0]      eg_data_o,
    output logic            eg_last_o,
    output vtie_eg_mode_t   eg_mode_o,
    output logic [11:0]     eg_vid_o,
    input  wire logic       out_valid_i,
    input  wire logic [7:0] out_data_i,
    input  wire logic       out_last_i
);
    // ============================================================
    // sink
    logic [7:0] rx[$];
    int         last_at;
    initial begin
        eg_valid_o = 1'b0;
        eg_data_o  = 8'h00;
        eg_last_o  = 1'b0;
        eg_mode_o  = EG_KEEP;
        eg_vid_o   = 12'h000;
        last_at    = 0;
    end
    always @(posedge clk_sys_i) begin
        if (out_valid_i) begin
            rx.push_back(out_data_i);
            if (out_last_i) begin
                last_at = rx.size();
            end
        end
    end
    // ============================================================
    // source: each byte held until an edge with ready high
    task send(input logic [7:0] frm[$], input vtie_eg_mode_t md, input logic [11:0] vid);
        foreach (frm[i]) begin
            eg_valid_o <= 1'b1;
            eg_data_o  <= frm[i];
            eg_last_o  <= (i == frm.size() - 1);
            eg_mode_o  <= md;
            eg_vid_o   <= vid;
            @(posedge clk_sys_i);
            while (!eg_ready_i) begin
                @(posedge clk_sys_i);
            end
        end
        eg_valid_o <= 1'b0;
        eg_last_o  <= 1'b0;
        eg_data_o  <= ~eg_data_o;
    endtask : send
endmodule : vtie_far_end
`default_nettype wire

// *** vtie_pkg.sv ***
// constants and types for the vlan tag ingress/egress block
// Notes on behaviour
// R1 - after reset one vlan exists, id 1
// R2 - management accepts only default vlan traffic
// R3 - forward only to ports of frame's vlan
// R4 - undefined vlan ids are never forwarded
// R5 - tagged frame takes the vlan id it carries
// R6 - single vlan untagged, several vlans tagged
// R7 - access port untagged frames get port default
// R8 - access to trunk egress inserts a tag
// R9 - trunk traffic tagged, trunk has default id
// R10 - trunk untagged frames get port default id
// R11 - one default vlan id per port
// R12 - trunk accepts extra tagged vlan list
// R13 - tagged frame leaving access port is stripped
// R14 - trunk egress in tagged list keeps tag
// R15 - vlan ids limited 1..4094, default 1
// R16 - every port resets to access type
// R17 - tagged list applies only on trunk ports
// R18 - 4-byte 0x8100 tag after source, new fcs
// R19 - vlan not on receiving port is discarded
// R20 - non-member egress ports removed from set
`default_nettype none
package vtie_pkg;
    // ============================================================
    // sizes
    localparam int          NPORT          = 5;
    localparam int          NVLAN          = 8;
    localparam int          PORT_W         = 3;
    // ============================================================
    // vlan ids
    localparam logic [11:0] VID_DEFAULT    = 12'h001;
    localparam logic [11:0] VID_MAX        = 12'hffe;
    localparam logic [11:0] VID_NONE       = 12'h000;
    // ============================================================
    // register map
    localparam logic [7:0]  ADDR_PORT_BASE = 8'h00;
    localparam logic [7:0]  ADDR_VLAN_BASE = 8'h40;
    localparam logic [7:0]  ADDR_STATUS    = 8'h80;
    localparam int          VID_LSB        = 0;
    localparam int          TRUNK_BIT      = 16;
    localparam int          VALID_BIT      = 15;
    localparam int          TLIST_LSB      = 16;
    localparam int          DROPCNT_LSB    = 0;
    localparam int          FWDCNT_LSB     = 16;
    // ============================================================
    // frame editing
    localparam logic [15:0] TPID           = 16'h8100;
    localparam logic [10:0] TAG_POS        = 11'h00c;
    localparam logic [10:0] CNT_MAX        = 11'h7ff;
    localparam logic [31:0] CRC_INIT       = 32'hffffffff;
    localparam logic [31:0] CRC_POLY       = 32'hedb88320;
    typedef enum logic [1:0] {EG_KEEP, EG_INSERT, EG_STRIP} vtie_eg_mode_t;
    typedef enum logic [1:0] {ED_DATA, ED_TAG, ED_FCS} vtie_ed_state_t;
endpackage : vtie_pkg
`default_nettype wire

// *** vtie_vlan_tag.sv ***
// vlan classification, membership filter and egress tag editor
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module vtie_vlan_tag
    import vtie_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    input  wire logic                cl_valid_i,
    input  wire logic [PORT_W-1:0]   cl_port_i,
    input  wire logic                cl_tagged_i,
    input  wire logic [11:0]         cl_vid_i,
    input  wire logic [NPORT-1:0]    cl_dest_i,
    input  wire logic                cl_to_mgmt_i,
    output logic                     cl_done_o,
    output logic                     cl_drop_o,
    output logic      [11:0]         cl_vid_o,
    output logic      [NPORT-1:0]    cl_fwd_o,
    output logic      [NPORT-1:0]    cl_tag_o,
    output logic                     cl_mgmt_o,
    input  wire logic                eg_valid_i,
    input  wire logic [7:0]          eg_data_i,
    input  wire logic                eg_last_i,
    input  wire vtie_eg_mode_t       eg_mode_i,
    input  wire logic [11:0]         eg_vid_i,
    output logic                     eg_ready_o,
    output logic                     out_valid_o,
    output logic      [7:0]          out_data_o,
    output logic                     out_last_o
);
    // ============================================================
    // state
    logic [11:0]       dvid_reg      [NPORT];
    logic [11:0]       dvid_next     [NPORT];
    logic [NPORT-1:0]  trunk_reg;
    logic [NPORT-1:0]  trunk_next;
    logic [11:0]       ent_vid_reg   [NVLAN];
    logic [11:0]       ent_vid_next  [NVLAN];
    logic [NVLAN-1:0]  ent_valid_reg;
    logic [NVLAN-1:0]  ent_valid_next;
    logic [NPORT-1:0]  ent_tl_reg    [NVLAN];
    logic [NPORT-1:0]  ent_tl_next   [NVLAN];
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [15:0]       drop_cnt_reg;
    logic [15:0]       drop_cnt_next;
    logic [15:0]       fwd_cnt_reg;
    logic [15:0]       fwd_cnt_next;

    // ============================================================
    // helpers
    function automatic logic vid_ok(input logic [11:0] v);
        vid_ok = (v != VID_NONE) && (v <= VID_MAX);
    endfunction : vid_ok

    function automatic logic port_member(input logic [11:0] dv, input logic tr, input logic tl, input logic [11:0] v);
        port_member = (dv == v) || (tr && tl); // R6 R11 R12 R17
    endfunction : port_member

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        crc_byte = x;
    endfunction : crc_byte

    // ============================================================
    // register file
    always_comb begin
        dvid_next      = dvid_reg;
        trunk_next     = trunk_reg;
        ent_vid_next   = ent_vid_reg;
        ent_valid_next = ent_valid_reg;
        ent_tl_next    = ent_tl_reg;
        rdata_next     = 32'h00000000;
        if (reg_wr_i) begin
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr_i == ADDR_PORT_BASE + 8'(4 * p) && vid_ok(reg_wdata_i[VID_LSB +: 12])) begin // R15
                    dvid_next[p]  = reg_wdata_i[VID_LSB +: 12];
                    trunk_next[p] = reg_wdata_i[TRUNK_BIT];
                end
            end
            for (int e = 0; e < NVLAN; e++) begin
                if (reg_addr_i == ADDR_VLAN_BASE + 8'(4 * e) &&
                    (!reg_wdata_i[VALID_BIT] || vid_ok(reg_wdata_i[VID_LSB +: 12]))) begin // R15
                    ent_vid_next[e]   = reg_wdata_i[VID_LSB +: 12];
                    ent_valid_next[e] = reg_wdata_i[VALID_BIT];
                    ent_tl_next[e]    = reg_wdata_i[TLIST_LSB +: NPORT];
                end
            end
        end
        if (reg_rd_i) begin
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr_i == ADDR_PORT_BASE + 8'(4 * p)) begin
                    rdata_next[VID_LSB +: 12]  = dvid_reg[p];
                    rdata_next[TRUNK_BIT]      = trunk_reg[p];
                end
            end
            for (int e = 0; e < NVLAN; e++) begin
                if (reg_addr_i == ADDR_VLAN_BASE + 8'(4 * e)) begin
                    rdata_next[VID_LSB +: 12]      = ent_vid_reg[e];
                    rdata_next[VALID_BIT]          = ent_valid_reg[e];
                    rdata_next[TLIST_LSB +: NPORT] = ent_tl_reg[e];
                end
            end
            if (reg_addr_i == ADDR_STATUS) begin
                rdata_next[DROPCNT_LSB +: 16] = drop_cnt_reg;
                rdata_next[FWDCNT_LSB +: 16]  = fwd_cnt_reg;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            for (int p = 0; p < NPORT; p++) begin
                dvid_reg[p] <= VID_DEFAULT; // R15 R11
            end
            trunk_reg <= '0; // R16
            for (int e = 0; e < NVLAN; e++) begin
                ent_vid_reg[e] <= (e == 0) ? VID_DEFAULT : VID_NONE; // R1
                ent_tl_reg[e]  <= '0;
            end
            ent_valid_reg <= NVLAN'(1); // R1 R2
            rdata_reg     <= 32'h00000000;
        end else begin
            dvid_reg      <= dvid_next;
            trunk_reg     <= trunk_next;
            ent_vid_reg   <= ent_vid_next;
            ent_valid_reg <= ent_valid_next;
            ent_tl_reg    <= ent_tl_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ============================================================
    // ingress classification and forwarding set
    logic [11:0]      cls_vid;
    logic             hit;
    logic [NPORT-1:0] hit_tl;
    logic [NPORT-1:0] mem_mask;
    logic             drop_now;
    logic             done_reg,  done_next;
    logic             drop_reg,  drop_next;
    logic [11:0]      cvid_reg,  cvid_next;
    logic [NPORT-1:0] fwd_reg,   fwd_next;
    logic [NPORT-1:0] tag_reg,   tag_next;
    logic             mgmt_reg,  mgmt_next;

    always_comb begin
        cls_vid = VID_NONE;
        if (cl_tagged_i) begin
            cls_vid = cl_vid_i; // R5
        end else if (32'(cl_port_i) < NPORT) begin
            cls_vid = dvid_reg[cl_port_i]; // R7 R10 R11
        end
        hit    = 1'b0;
        hit_tl = '0;
        for (int e = 0; e < NVLAN; e++) begin
            if (ent_valid_reg[e] && ent_vid_reg[e] == cls_vid && vid_ok(cls_vid)) begin // R4
                hit    = 1'b1;
                hit_tl = ent_tl_reg[e];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_member
            assign mem_mask[g] = port_member(dvid_reg[g], trunk_reg[g], hit_tl[g], cls_vid); // R3 R20
        end
    endgenerate

    always_comb begin
        drop_now = 1'b1;
        for (int p = 0; p < NPORT; p++) begin
            if (32'(cl_port_i) == p && hit && mem_mask[p]) begin // R4 R19
                drop_now = 1'b0;
            end
        end
    end

    always_comb begin
        done_next     = cl_valid_i;
        drop_next     = 1'b0;
        cvid_next     = cvid_reg;
        fwd_next      = '0;
        tag_next      = '0;
        mgmt_next     = 1'b0;
        drop_cnt_next = drop_cnt_reg;
        fwd_cnt_next  = fwd_cnt_reg;
        if (cl_valid_i) begin
            cvid_next = cls_vid;
            drop_next = drop_now;
            if (drop_now) begin
                drop_cnt_next = drop_cnt_reg + 16'h0001;
            end else begin
                fwd_next     = cl_dest_i & mem_mask & ~(NPORT'(1) << cl_port_i); // R3 R20
                tag_next     = cl_dest_i & mem_mask & ~(NPORT'(1) << cl_port_i) & trunk_reg; // R8 R9 R13 R14
                mgmt_next    = cl_to_mgmt_i && cls_vid == VID_DEFAULT; // R2
                fwd_cnt_next = fwd_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            done_reg     <= 1'b0;
            drop_reg     <= 1'b0;
            cvid_reg     <= VID_NONE;
            fwd_reg      <= '0;
            tag_reg      <= '0;
            mgmt_reg     <= 1'b0;
            drop_cnt_reg <= 16'h0000;
            fwd_cnt_reg  <= 16'h0000;
        end else begin
            done_reg     <= done_next;
            drop_reg     <= drop_next;
            cvid_reg     <= cvid_next;
            fwd_reg      <= fwd_next;
            tag_reg      <= tag_next;
            mgmt_reg     <= mgmt_next;
            drop_cnt_reg <= drop_cnt_next;
            fwd_cnt_reg  <= fwd_cnt_next;
        end
    end

    assign cl_done_o = done_reg;
    assign cl_drop_o = drop_reg;
    assign cl_vid_o  = cvid_reg;
    assign cl_fwd_o  = fwd_reg;
    assign cl_tag_o  = tag_reg;
    assign cl_mgmt_o = mgmt_reg;

    // ============================================================
    // egress tag editor
    vtie_ed_state_t st_reg,   st_next;
    vtie_eg_mode_t  mode_reg, mode_next;
    vtie_eg_mode_t  cur_mode;
    logic [10:0]    cnt_reg,  cnt_next;
    logic [1:0]     sub_reg,  sub_next;
    logic           tagd_reg, tagd_next;
    logic [11:0]    evid_reg, evid_next;
    logic [31:0]    crc_reg,  crc_next;
    logic [7:0]     od_reg,   od_next;
    logic           ov_reg,   ov_next;
    logic           ol_reg,   ol_next;
    logic           ins_pend;
    logic           strip_byte;
    logic [7:0]     tag_byte;

    assign cur_mode   = (cnt_reg == 11'h000) ? eg_mode_i : mode_reg;
    assign ins_pend   = st_reg == ED_DATA && mode_reg == EG_INSERT && cnt_reg == TAG_POS && !tagd_reg; // R8
    assign strip_byte = cur_mode == EG_STRIP && cnt_reg >= TAG_POS && cnt_reg < TAG_POS + 11'h004; // R13
    assign eg_ready_o = st_reg == ED_DATA && !ins_pend;

    always_comb begin
        case (sub_reg)
            2'h0:    tag_byte = TPID[15:8]; // R18
            2'h1:    tag_byte = TPID[7:0];
            2'h2:    tag_byte = {4'h0, evid_reg[11:8]};
            default: tag_byte = evid_reg[7:0];
        endcase
    end

    always_comb begin
        st_next   = st_reg;
        mode_next = mode_reg;
        cnt_next  = cnt_reg;
        sub_next  = sub_reg;
        tagd_next = tagd_reg;
        evid_next = evid_reg;
        crc_next  = crc_reg;
        od_next   = 8'h00;
        ov_next   = 1'b0;
        ol_next   = 1'b0;
        case (st_reg)
            ED_DATA: begin
                if (ins_pend) begin
                    st_next  = ED_TAG;
                    sub_next = 2'h0;
                end else if (eg_valid_i) begin
                    if (cnt_reg == 11'h000) begin
                        mode_next = eg_mode_i;
                        evid_next = eg_vid_i;
                    end
                    if (!strip_byte) begin
                        od_next  = eg_data_i;
                        ov_next  = 1'b1;
                        crc_next = crc_byte(crc_reg, eg_data_i);
                    end
                    cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 11'h001;
                    if (eg_last_i) begin
                        st_next   = ED_FCS;
                        sub_next  = 2'h0;
                        cnt_next  = 11'h000;
                        tagd_next = 1'b0;
                    end
                end
            end
            ED_TAG: begin
                od_next  = tag_byte; // R18
                ov_next  = 1'b1;
                crc_next = crc_byte(crc_reg, tag_byte);
                sub_next = sub_reg + 2'h1;
                if (sub_reg == 2'h3) begin
                    st_next   = ED_DATA;
                    tagd_next = 1'b1;
                end
            end
            ED_FCS: begin
                od_next  = ~crc_reg[8 * sub_reg +: 8]; // R18
                ov_next  = 1'b1;
                ol_next  = sub_reg == 2'h3;
                sub_next = sub_reg + 2'h1;
                if (sub_reg == 2'h3) begin
                    st_next  = ED_DATA;
                    crc_next = CRC_INIT;
                end
            end
            default: begin
                st_next = ED_DATA;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_reg   <= ED_DATA;
            mode_reg <= EG_KEEP;
            cnt_reg  <= 11'h000;
            sub_reg  <= 2'h0;
            tagd_reg <= 1'b0;
            evid_reg <= VID_NONE;
            crc_reg  <= CRC_INIT;
            od_reg   <= 8'h00;
            ov_reg   <= 1'b0;
            ol_reg   <= 1'b0;
        end else begin
            st_reg   <= st_next;
            mode_reg <= mode_next;
            cnt_reg  <= cnt_next;
            sub_reg  <= sub_next;
            tagd_reg <= tagd_next;
            evid_reg <= evid_next;
            crc_reg  <= crc_next;
            od_reg   <= od_next;
            ov_reg   <= ov_next;
            ol_reg   <= ol_next;
        end
    end

    assign out_valid_o = ov_reg;
    assign out_data_o  = od_reg;
    assign out_last_o  = ol_reg;

    // ============================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence ins_start_s;
        ins_pend;
    endsequence
    sequence tag_bytes_s;
        (out_valid_o && out_data_o == TPID[15:8]) ##1 (out_valid_o && out_data_o == TPID[7:0])
        ##1 out_valid_o ##1 (out_valid_o && out_data_o == evid_reg[7:0]);
    endsequence
    sequence frame_end_s;
        eg_valid_i && eg_ready_o && eg_last_i;
    endsequence

    default_vlan_a: assert property ($fell(reset_i) |-> ent_valid_reg[0] && ent_vid_reg[0] == VID_DEFAULT // R1
                                     && trunk_reg == '0)
        else $error("default vlan or access type missing after reset");
    mgmt_vlan_a: assert property (cl_mgmt_o |-> cl_vid_o == VID_DEFAULT && !cl_drop_o) // R2
        else $error("management accepted a non default vlan");
    fwd_member_a: assert property (cl_valid_i |=> (cl_fwd_o & ~$past(mem_mask)) == '0) // R3
        else $error("frame forwarded to a non member port");
    undef_drop_a: assert property (cl_valid_i && !hit |=> cl_drop_o && cl_fwd_o == '0) // R4
        else $error("undefined vlan was forwarded");
    tagged_class_a: assert property (cl_valid_i && cl_tagged_i |=> cl_vid_o == $past(cl_vid_i)) // R5
        else $error("tagged frame lost its carried vlan id");
    untag_class_a: assert property (cl_valid_i && !cl_tagged_i && cl_port_i == '0 // R7
                                    |=> cl_vid_o == $past(dvid_reg[0]))
        else $error("untagged frame not given port default id");
    access_strip_a: assert property (cl_done_o |-> (cl_tag_o & ~trunk_reg) == '0) // R13
        else $error("tag kept toward an access port");
    trunk_tag_a: assert property (cl_done_o && !cl_drop_o |-> cl_tag_o == (cl_fwd_o & trunk_reg)) // R8
        else $error("trunk egress not tagged");
    dvid_range_a: assert property (reg_wr_i && reg_addr_i == ADDR_PORT_BASE + 8'(4 * 1) // R15
                                   && !vid_ok(reg_wdata_i[VID_LSB +: 12]) |=> $stable(dvid_reg[1]))
        else $error("out of range default vlan id stored");
    list_access_a: assert property (cl_valid_i && !trunk_reg[0] && cls_vid != dvid_reg[0] // R17
                                    |=> !cl_fwd_o[0])
        else $error("tagged list used on an access port");
    tag_insert_a: assert property (ins_start_s |=> ##1 tag_bytes_s) // R18
        else $error("inserted tag bytes wrong");
    fcs_tail_a: assert property (frame_end_s |=> (out_valid_o && !out_last_o)[*4] ##1 (out_valid_o && out_last_o)) // R18
        else $error("fcs not appended after frame end");
    strip_gap_a: assert property (eg_valid_i && eg_ready_o && strip_byte |=> !out_valid_o) // R13
        else $error("stripped tag byte reached the output");
endmodule : vtie_vlan_tag
`default_nettype wire
